/* File: logic/ibpc_pkg.sv */
// Shared constants and types for the two-wire bus core
package ibpc_pkg;
  localparam int CW_W = 16;
  localparam int ON_BIT = 15;
  localparam int DIV_W = 8;
  localparam int ADDR_W = 7;
  localparam logic [DIV_W-1:0] DIV_ZERO = 8'h00;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [3:0] BIT_ONE = 4'h1;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_ACK = 4'h9;
  typedef enum logic [2:0] {
    IBPC_CMD_START, IBPC_CMD_RSTART, IBPC_CMD_STOP, IBPC_CMD_WRITE, IBPC_CMD_READ
  } ibpc_cmd_t;
  typedef struct packed {
    ibpc_cmd_t code;
    logic [7:0] tx;
    logic nack;
  } ibpc_req_t;
  typedef struct packed {
    logic master;
    logic slave;
    logic collide;
  } ibpc_ev_t;
endpackage

/* File: logic/ibpc_core.sv */
// Two-wire bus master and slave core with a separate bus-sampling clock
`timescale 1ns/1ps

module ibpc_sync #(
  parameter logic INIT = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic meta_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= INIT;
      q <= INIT;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

module ibpc_core (
  input wire logic clk,
  input wire logic nrst,
  input wire logic link_clk,
  input wire logic [ibpc_pkg::CW_W-1:0] control_word,
  input wire logic req_valid,
  input wire ibpc_pkg::ibpc_req_t req,
  input wire logic [ibpc_pkg::DIV_W-1:0] rate_divider,
  input wire logic [ibpc_pkg::ADDR_W-1:0] own_addr,
  input wire logic [7:0] slave_tx,
  output logic req_busy,
  output logic [7:0] rx_byte,
  output logic ack_seen,
  output logic master_event_flag,
  output logic slave_event_flag,
  output logic collision_event_flag,
  input wire logic bus_clock_pin_in,
  output logic bus_clock_pin_out,
  output logic bus_clock_pin_oe,
  input wire logic bus_data_pin_in,
  output logic bus_data_pin_out,
  output logic bus_data_pin_oe
);
  typedef enum logic [3:0] {
    M_IDLE, M_START, M_HOLD, M_RS_A, M_RS_B, M_SP_A, M_SP_B, M_SP_C, M_LOW, M_HIGH
  } ibpc_mst_t;
  typedef enum logic [1:0] {S_IDLE, S_SHIFT, S_ACK, S_SEND} ibpc_slv_t;

  ibpc_pkg::ibpc_req_t req_r;
  ibpc_pkg::ibpc_ev_t ev_t_r, ev_s, ev_d_r;
  logic m_tgl_r, s_tgl_r, b_tgl_r;
  // One writing process per toggle bit
  assign ev_t_r = '{master: m_tgl_r, slave: s_tgl_r, collide: b_tgl_r};
  logic req_tgl_r;
  logic lrst_n, on_s, req_s, req_p_r, go;
  logic scl_s, sda_s, scl_p_r, sda_p_r;
  logic start_det, stop_det, scl_rise, scl_fall, bus_busy_r;
  ibpc_mst_t m_st_r;
  logic [ibpc_pkg::DIV_W-1:0] cnt_r;
  logic cnt_zero;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic rd_r, m_scl_r, m_sda_r, ack_r;
  ibpc_slv_t s_st_r;
  logic [3:0] s_bit_r;
  logic [7:0] s_sh_r, s_rx_r;
  logic s_adr_r, s_rw_r, s_sda_r, s_ack_r;

  // Software side: one command in flight, no queueing
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      req_r <= '0;
      req_tgl_r <= 1'b0;
      req_busy <= 1'b0;
    end else if (req_valid && !req_busy && control_word[ibpc_pkg::ON_BIT]) begin
      req_r <= req;
      req_tgl_r <= ~req_tgl_r;
      req_busy <= 1'b1;
    end else if ((ev_s.master ^ ev_d_r.master) || (ev_s.collide ^ ev_d_r.collide)) begin
      req_busy <= 1'b0;
    end
  end

  // Event toggles come back over two flops each
  ibpc_sync u_ev_m (.clk(clk), .rst_n(nrst), .d(ev_t_r.master), .q(ev_s.master));
  ibpc_sync u_ev_s (.clk(clk), .rst_n(nrst), .d(ev_t_r.slave), .q(ev_s.slave));
  ibpc_sync u_ev_b (.clk(clk), .rst_n(nrst), .d(ev_t_r.collide), .q(ev_s.collide));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ev_d_r <= '0;
      master_event_flag <= 1'b0;
      slave_event_flag <= 1'b0;
      collision_event_flag <= 1'b0;
    end else begin
      ev_d_r <= ev_s;
      master_event_flag <= ev_s.master ^ ev_d_r.master;
      slave_event_flag <= ev_s.slave ^ ev_d_r.slave;
      collision_event_flag <= ev_s.collide ^ ev_d_r.collide;
    end
  end

  // Link values stay still until the next byte, so a late capture is safe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_byte <= 8'h00;
      ack_seen <= 1'b0;
    end else if (ev_s.master ^ ev_d_r.master) begin
      rx_byte <= sh_r;
      ack_seen <= ack_r;
    end else if (ev_s.slave ^ ev_d_r.slave) begin
      rx_byte <= s_rx_r;
      ack_seen <= s_ack_r;
    end
  end

  // Link side: reset release and level crossings
  ibpc_sync u_lrst (.clk(link_clk), .rst_n(nrst), .d(1'b1), .q(lrst_n));
  ibpc_sync u_on (.clk(link_clk), .rst_n(lrst_n), .d(control_word[ibpc_pkg::ON_BIT]),
    .q(on_s));
  ibpc_sync u_req (.clk(link_clk), .rst_n(lrst_n), .d(req_tgl_r), .q(req_s));
  ibpc_sync #(.INIT(1'b1)) u_scl (.clk(link_clk), .rst_n(lrst_n), .d(bus_clock_pin_in),
    .q(scl_s));
  ibpc_sync #(.INIT(1'b1)) u_sda (.clk(link_clk), .rst_n(lrst_n), .d(bus_data_pin_in),
    .q(sda_s));

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      req_p_r <= 1'b0;
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
    end else begin
      req_p_r <= req_s;
      scl_p_r <= scl_s;
      sda_p_r <= sda_s;
    end
  end

  assign go = req_s ^ req_p_r;
  assign start_det = scl_s && scl_p_r && sda_p_r && !sda_s;
  assign stop_det = scl_s && scl_p_r && !sda_p_r && sda_s;
  assign scl_rise = scl_s && !scl_p_r;
  assign scl_fall = !scl_s && scl_p_r;
  assign cnt_zero = cnt_r == ibpc_pkg::DIV_ZERO;

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      bus_busy_r <= 1'b0;
    end else if (!on_s || stop_det) begin
      bus_busy_r <= 1'b0;
    end else if (start_det) begin
      bus_busy_r <= 1'b1;
    end
  end

  // Master sequencer; the unit never needs more than one divider step at once
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      m_st_r <= M_IDLE;
      cnt_r <= ibpc_pkg::DIV_ZERO;
      bit_r <= ibpc_pkg::BIT_ZERO;
      sh_r <= 8'h00;
      rd_r <= 1'b0;
      m_scl_r <= 1'b0;
      m_sda_r <= 1'b0;
      ack_r <= 1'b0;
      m_tgl_r <= 1'b0;
      b_tgl_r <= 1'b0;
    end else if (!on_s) begin
      m_st_r <= M_IDLE;
      m_scl_r <= 1'b0;
      m_sda_r <= 1'b0;
      cnt_r <= ibpc_pkg::DIV_ZERO;
    end else begin
      if (!cnt_zero) begin
        cnt_r <= cnt_r - 8'h01;
      end
      unique case (m_st_r)
        M_IDLE: if (go) begin
          if (req_r.code == ibpc_pkg::IBPC_CMD_START && !bus_busy_r && scl_s && sda_s) begin
            m_sda_r <= 1'b1;
            cnt_r <= rate_divider;
            m_st_r <= M_START;
          end else begin
            b_tgl_r <= ~b_tgl_r;
          end
        end
        M_START: if (cnt_zero) begin
          m_scl_r <= 1'b1;
          m_tgl_r <= ~m_tgl_r;
          m_st_r <= M_HOLD;
        end
        M_HOLD: if (go) begin
          cnt_r <= rate_divider;
          unique case (req_r.code)
            ibpc_pkg::IBPC_CMD_RSTART: begin
              m_sda_r <= 1'b0;
              m_st_r <= M_RS_A;
            end
            ibpc_pkg::IBPC_CMD_STOP: begin
              m_sda_r <= 1'b1;
              m_st_r <= M_SP_A;
            end
            ibpc_pkg::IBPC_CMD_WRITE, ibpc_pkg::IBPC_CMD_READ: begin
              sh_r <= req_r.tx;
              rd_r <= req_r.code == ibpc_pkg::IBPC_CMD_READ;
              bit_r <= ibpc_pkg::BIT_ZERO;
              m_st_r <= M_LOW;
            end
            default: b_tgl_r <= ~b_tgl_r;
          endcase
        end
        M_RS_A: if (cnt_zero) begin
          m_scl_r <= 1'b0;
          cnt_r <= rate_divider;
          m_st_r <= M_RS_B;
        end
        M_RS_B: if (!scl_s) begin
          cnt_r <= rate_divider;
        end else if (cnt_zero) begin
          if (!sda_s) begin
            b_tgl_r <= ~b_tgl_r;
            m_st_r <= M_IDLE;
          end else begin
            m_sda_r <= 1'b1;
            cnt_r <= rate_divider;
            m_st_r <= M_START;
          end
        end
        M_SP_A: if (cnt_zero) begin
          m_scl_r <= 1'b0;
          cnt_r <= rate_divider;
          m_st_r <= M_SP_B;
        end
        M_SP_B: if (!scl_s) begin
          cnt_r <= rate_divider;
        end else if (cnt_zero) begin
          m_sda_r <= 1'b0;
          cnt_r <= rate_divider;
          m_st_r <= M_SP_C;
        end
        M_SP_C: if (cnt_zero) begin
          if (sda_s) begin
            m_tgl_r <= ~m_tgl_r;
          end else begin
            b_tgl_r <= ~b_tgl_r;
          end
          m_st_r <= M_IDLE;
        end
        M_LOW: begin
          // Data moves one cycle after the clock went low
          if (bit_r == ibpc_pkg::BIT_LAST) begin
            m_sda_r <= rd_r && !req_r.nack;
          end else begin
            m_sda_r <= !rd_r && !sh_r[7];
          end
          if (cnt_zero) begin
            m_scl_r <= 1'b0;
            cnt_r <= rate_divider;
            m_st_r <= M_HIGH;
          end
        end
        M_HIGH: if (!scl_s) begin
          cnt_r <= rate_divider;
        end else if (cnt_zero) begin
          m_scl_r <= 1'b1;
          cnt_r <= rate_divider;
          if (bit_r == ibpc_pkg::BIT_LAST) begin
            ack_r <= !sda_s;
            m_tgl_r <= ~m_tgl_r;
            m_st_r <= M_HOLD;
          end else if (!rd_r && !m_sda_r && !sda_s) begin
            // Lost arbitration: drop the bus at once
            m_scl_r <= 1'b0;
            b_tgl_r <= ~b_tgl_r;
            m_st_r <= M_IDLE;
          end else begin
            sh_r <= {sh_r[6:0], sda_s};
            bit_r <= bit_r + ibpc_pkg::BIT_ONE;
            m_st_r <= M_LOW;
          end
        end
        default: m_st_r <= M_IDLE;
      endcase
    end
  end

  // Slave listener; it also hears this unit's own master traffic
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      s_st_r <= S_IDLE;
      s_bit_r <= ibpc_pkg::BIT_ZERO;
      s_sh_r <= 8'h00;
      s_rx_r <= 8'h00;
      s_adr_r <= 1'b0;
      s_rw_r <= 1'b0;
      s_sda_r <= 1'b0;
      s_ack_r <= 1'b0;
      s_tgl_r <= 1'b0;
    end else if (!on_s || stop_det) begin
      s_st_r <= S_IDLE;
      s_sda_r <= 1'b0;
    end else if (start_det) begin
      s_st_r <= S_SHIFT;
      s_bit_r <= ibpc_pkg::BIT_ZERO;
      s_adr_r <= 1'b1;
      s_sda_r <= 1'b0;
    end else begin
      unique case (s_st_r)
        S_IDLE: s_sda_r <= 1'b0;
        S_SHIFT: begin
          if (scl_rise) begin
            s_sh_r <= {s_sh_r[6:0], sda_s};
            s_bit_r <= s_bit_r + ibpc_pkg::BIT_ONE;
          end
          if (scl_fall && s_bit_r == ibpc_pkg::BIT_LAST) begin
            if (!s_adr_r || s_sh_r[7:1] == own_addr) begin
              s_sda_r <= 1'b1;
              s_rx_r <= s_sh_r;
              if (s_adr_r) begin
                s_rw_r <= s_sh_r[0];
              end
              s_st_r <= S_ACK;
            end else begin
              s_st_r <= S_IDLE;
            end
          end
        end
        S_ACK: if (scl_fall) begin
          s_tgl_r <= ~s_tgl_r;
          s_adr_r <= 1'b0;
          s_bit_r <= ibpc_pkg::BIT_ZERO;
          s_ack_r <= 1'b1;
          if (s_rw_r) begin
            s_sh_r <= slave_tx;
            s_sda_r <= !slave_tx[7];
            s_st_r <= S_SEND;
          end else begin
            s_sda_r <= 1'b0;
            s_st_r <= S_SHIFT;
          end
        end
        S_SEND: begin
          if (scl_rise) begin
            s_bit_r <= s_bit_r + ibpc_pkg::BIT_ONE;
            if (s_bit_r == ibpc_pkg::BIT_LAST) begin
              s_ack_r <= !sda_s;
            end
          end
          if (scl_fall) begin
            if (s_bit_r == ibpc_pkg::BIT_ACK) begin
              s_tgl_r <= ~s_tgl_r;
              s_bit_r <= ibpc_pkg::BIT_ZERO;
              s_sh_r <= slave_tx;
              s_sda_r <= s_ack_r && !slave_tx[7];
              s_st_r <= s_ack_r ? S_SEND : S_IDLE;
            end else if (s_bit_r == ibpc_pkg::BIT_LAST) begin
              s_sda_r <= 1'b0;
            end else begin
              s_sh_r <= {s_sh_r[6:0], 1'b0};
              s_sda_r <= !s_sh_r[6];
            end
          end
        end
      endcase
    end
  end

  // Pins: only pull-downs, a wired-AND with the other parties
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      bus_clock_pin_out <= 1'b0;
      bus_data_pin_out <= 1'b0;
      bus_clock_pin_oe <= 1'b0;
      bus_data_pin_oe <= 1'b0;
    end else begin
      bus_clock_pin_out <= 1'b0;
      bus_data_pin_out <= 1'b0;
      bus_clock_pin_oe <= on_s && m_scl_r;
      bus_data_pin_oe <= on_s && (m_sda_r || s_sda_r);
    end
  end

  sequence seq_stop_done;
    m_st_r == M_SP_C && cnt_zero && sda_s && on_s;
  endsequence

  sequence seq_start_done;
    m_st_r == M_START && cnt_zero && on_s;
  endsequence

  chk_pins_released: assert property (@(posedge link_clk) disable iff (!lrst_n)
    !on_s |=> ##1 !bus_clock_pin_oe && !bus_data_pin_oe)
    else $error("pins driven while disabled");
  chk_open_drain: assert property (@(posedge link_clk) disable iff (!lrst_n)
    !bus_clock_pin_out && !bus_data_pin_out)
    else $error("pin driven high");
  chk_start_event: assert property (@(posedge link_clk) disable iff (!lrst_n)
    seq_start_done |=> m_st_r == M_HOLD && m_scl_r && $changed(ev_t_r.master))
    else $error("start event missing");
  chk_stop_event: assert property (@(posedge link_clk) disable iff (!lrst_n)
    seq_stop_done |=> m_st_r == M_IDLE && !m_sda_r && $changed(ev_t_r.master))
    else $error("stop event missing");
  chk_data_low_clock: assert property (@(posedge link_clk) disable iff (!lrst_n)
    (m_st_r == M_LOW && $changed(m_sda_r)) |-> $past(m_scl_r))
    else $error("data moved with clock released");
  chk_ninth_event: assert property (@(posedge link_clk) disable iff (!lrst_n)
    (m_st_r == M_HIGH && scl_s && cnt_zero && bit_r == ibpc_pkg::BIT_LAST && on_s)
    |=> m_scl_r && m_st_r == M_HOLD && $changed(ev_t_r.master))
    else $error("ninth clock event missing");
  chk_idle_bus_only: assert property (@(posedge link_clk) disable iff (!lrst_n)
    (m_st_r == M_IDLE && go && bus_busy_r) |=> m_st_r == M_IDLE && !m_sda_r)
    else $error("start on a busy bus");
  chk_stop_frees_bus: assert property (@(posedge link_clk) disable iff (!lrst_n)
    stop_det |=> !bus_busy_r && s_st_r == S_IDLE)
    else $error("stop not seen");
  chk_start_arms_slave: assert property (@(posedge link_clk) disable iff (!lrst_n)
    (start_det && on_s) |=> s_st_r == S_SHIFT && s_adr_r && s_bit_r == ibpc_pkg::BIT_ZERO)
    else $error("start not seen by slave");
  chk_event_pulse: assert property (@(posedge clk) disable iff (!nrst)
    master_event_flag |=> !master_event_flag ##1 !master_event_flag)
    else $error("event pulse too long");
endmodule

/* File: tb/ibpc_slave_model.sv */
// Behavioural bus slave that stands on the far side of the core
`timescale 1ns/1ps
module ibpc_slave_model #(
  parameter logic [6:0] ADDR = 7'h50,
  parameter logic [7:0] RDATA = 8'hA5
) (
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe,
  output logic [7:0] last_rx
);
  logic [7:0] sh;
  logic act, rd, adr;
  int cnt;
  // Clock is only listened to, never held: no stretching here
  initial begin
    sda_oe = 1'b0;
    act = 1'b0;
    rd = 1'b0;
    adr = 1'b0;
    cnt = 0;
    sh = 8'h00;
    last_rx = 8'h00;
  end
  always @(negedge sda) begin
    if (scl) begin
      act = 1'b1;
      adr = 1'b1;
      rd = 1'b0;
      cnt = 0;
    end
  end
  always @(posedge sda) begin
    if (scl) begin
      act = 1'b0;
      sda_oe = 1'b0;
    end
  end
  always @(posedge scl) begin
    if (act) begin
      if (cnt < 8) sh = {sh[6:0], sda};
      else if (rd && cnt == 8 && sda) act = 1'b0;
      cnt = cnt + 1;
    end
  end
  // Drive changes only with the clock low; open-drain enable only
  always @(negedge scl) begin
    if (act) begin
      if (cnt == 8) begin
        if (adr && sh[7:1] != ADDR) act = 1'b0;
        else if (adr) rd = sh[0];
        else if (!rd) last_rx = sh;
        sda_oe = act && (adr || !rd);
      end else if (cnt == 9) begin
        cnt = 0;
        adr = 1'b0;
        sda_oe = rd && !RDATA[7];
      end else if (rd && !adr) sda_oe = !RDATA[7-cnt];
    end
  end
endmodule

/* File: tb/i2c_bus_protocol_core_test.sv */
// Self-checking bench for the two-wire bus core
`timescale 1ns/1ps
module i2c_bus_protocol_core_test;
  logic clk, nrst, link_clk, req_valid, req_busy, ack_seen;
  logic [15:0] control_word;
  ibpc_pkg::ibpc_req_t req;
  logic [7:0] rx_byte, mdl_rx;
  logic mev, sev, cev, scl_oe, sda_oe, scl_out, sda_out, mdl_oe, scl, sda;
  logic m_got, c_got;
  int n_fail, comparisons, sev_n, cev_n;
  // Pull-ups make released lines read high
  assign scl = !scl_oe;
  assign sda = !(sda_oe || mdl_oe);

  ibpc_core DUT (
    .clk(clk), .nrst(nrst), .link_clk(link_clk), .control_word(control_word),
    .req_valid(req_valid), .req(req), .rate_divider(8'h04), .own_addr(7'h2A),
    .slave_tx(8'h5A), .req_busy(req_busy), .rx_byte(rx_byte), .ack_seen(ack_seen),
    .master_event_flag(mev), .slave_event_flag(sev), .collision_event_flag(cev),
    .bus_clock_pin_in(scl), .bus_clock_pin_out(scl_out), .bus_clock_pin_oe(scl_oe),
    .bus_data_pin_in(sda), .bus_data_pin_out(sda_out), .bus_data_pin_oe(sda_oe)
  );
  ibpc_slave_model mdl (.scl(scl), .sda(sda), .sda_oe(mdl_oe), .last_rx(mdl_rx));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = !clk;
  end
  // Offset start keeps the link clock out of phase with clk
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = !link_clk;
  end
  always @(negedge clk) begin
    if (sev === 1'b1) sev_n++;
    if (cev === 1'b1) cev_n++;
  end

  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One request; waits, bounded, for its master or collision event
  task automatic do_req(input ibpc_pkg::ibpc_cmd_t c, input logic [7:0] d, input logic nk);
    int i;
    @(negedge clk);
    req = '{code: c, tx: d, nack: nk};
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    for (i = 0; i < 3000 && mev !== 1'b1 && cev !== 1'b1; i++) @(negedge clk);
    m_got = (mev === 1'b1);
    c_got = (cev === 1'b1);
    if (i == 3000) begin
      n_fail++;
      $display("BAD %0t no answer", $time);
      print_verdict();
    end
  endtask
  task automatic idle_chk(input string msg);
    repeat (20) @(negedge clk);
    chk(scl === 1'b1 && sda === 1'b1 && scl_oe === 1'b0, msg);
  endtask

  task automatic t_disabled;
    control_word = 16'h0000;
    req = '{code: ibpc_pkg::IBPC_CMD_START, tx: 8'h00, nack: 1'b0};
    req_valid = 1'b1;
    repeat (20) @(negedge clk);
    req_valid = 1'b0;
    chk(req_busy === 1'b0 && sda_oe === 1'b0, "request taken while off");
    control_word = 16'h8000;
    repeat (12) @(negedge clk);
    chk(sda_oe === 1'b0 && scl_oe === 1'b0 && mev === 1'b0, "lines held on enable");
    $display("done disabled");
  endtask
  task automatic t_write;
    do_req(ibpc_pkg::IBPC_CMD_START, 8'h00, 1'b0);
    chk(m_got && sda === 1'b0, "start event");
    do_req(ibpc_pkg::IBPC_CMD_WRITE, 8'hA0, 1'b0);
    chk(m_got && ack_seen === 1'b1, "address not acked");
    do_req(ibpc_pkg::IBPC_CMD_WRITE, 8'h3C, 1'b0);
    chk(ack_seen === 1'b1 && mdl_rx === 8'h3C, "data byte");
    do_req(ibpc_pkg::IBPC_CMD_STOP, 8'h00, 1'b0);
    chk(m_got, "stop event");
    idle_chk("idle after write");
    $display("done write");
  endtask
  task automatic t_nack;
    do_req(ibpc_pkg::IBPC_CMD_START, 8'h00, 1'b0);
    do_req(ibpc_pkg::IBPC_CMD_WRITE, 8'h66, 1'b0);
    chk(m_got && ack_seen === 1'b0, "absent slave acked");
    do_req(ibpc_pkg::IBPC_CMD_STOP, 8'h00, 1'b0);
    idle_chk("idle after nack");
    $display("done nack");
  endtask
  task automatic t_read;
    do_req(ibpc_pkg::IBPC_CMD_START, 8'h00, 1'b0);
    do_req(ibpc_pkg::IBPC_CMD_WRITE, 8'hA0, 1'b0);
    do_req(ibpc_pkg::IBPC_CMD_WRITE, 8'h07, 1'b0);
    do_req(ibpc_pkg::IBPC_CMD_RSTART, 8'h00, 1'b0);
    chk(m_got, "repeated start event");
    do_req(ibpc_pkg::IBPC_CMD_WRITE, 8'hA1, 1'b0);
    chk(ack_seen === 1'b1, "read address not acked");
    do_req(ibpc_pkg::IBPC_CMD_READ, 8'h00, 1'b0);
    chk(m_got && rx_byte === 8'hA5, "first read byte");
    do_req(ibpc_pkg::IBPC_CMD_READ, 8'h00, 1'b1);
    chk(rx_byte === 8'hA5, "last read byte");
    do_req(ibpc_pkg::IBPC_CMD_STOP, 8'h00, 1'b0);
    idle_chk("idle after read");
    $display("done read");
  endtask
  task automatic t_self;
    sev_n = 0;
    do_req(ibpc_pkg::IBPC_CMD_START, 8'h00, 1'b0);
    do_req(ibpc_pkg::IBPC_CMD_WRITE, 8'h54, 1'b0);
    // Slave event trails the master event by a few link cycles
    repeat (10) @(negedge clk);
    chk(ack_seen === 1'b1 && sev_n == 1, "own address");
    do_req(ibpc_pkg::IBPC_CMD_WRITE, 8'hC3, 1'b0);
    repeat (10) @(negedge clk);
    chk(sev_n == 2 && rx_byte === 8'hC3, "own data byte");
    do_req(ibpc_pkg::IBPC_CMD_STOP, 8'h00, 1'b0);
    idle_chk("idle after self");
    $display("done self");
  endtask
  task automatic t_self_read;
    sev_n = 0;
    do_req(ibpc_pkg::IBPC_CMD_START, 8'h00, 1'b0);
    do_req(ibpc_pkg::IBPC_CMD_WRITE, 8'h55, 1'b0);
    chk(m_got && ack_seen === 1'b1, "own read address");
    do_req(ibpc_pkg::IBPC_CMD_READ, 8'h00, 1'b1);
    chk(m_got && rx_byte === 8'h5A && ack_seen === 1'b0, "own slave reply");
    repeat (10) @(negedge clk);
    chk(sev_n == 2, "own reply events");
    do_req(ibpc_pkg::IBPC_CMD_STOP, 8'h00, 1'b0);
    idle_chk("idle after self read");
    $display("done self read");
  endtask
  task automatic t_refuse;
    cev_n = 0;
    do_req(ibpc_pkg::IBPC_CMD_READ, 8'h00, 1'b0);
    repeat (2) @(negedge clk);
    chk(c_got && !m_got && cev_n == 1, "read without start");
    idle_chk("bus moved on refusal");
    $display("done refuse");
  endtask

  initial begin
    nrst = 1'b0;
    control_word = 16'h0000;
    req_valid = 1'b0;
    req = '0;
    n_fail = 0;
    comparisons = 0;
    repeat (20) @(negedge clk);
    chk(scl_oe === 1'b0 && sda_oe === 1'b0 && mev === 1'b0, "reset state");
    chk(scl_out === 1'b0 && sda_out === 1'b0, "pins drive high");
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    t_disabled();
    t_write();
    t_nack();
    t_read();
    t_self();
    t_self_read();
    t_refuse();
    print_verdict();
  end
endmodule
